// *** hw/vpcm_device.sv ***
// Codec end of the voice PCM serial port, link logic on the bit clock
`timescale 1ns/1ns
module vpcm_device
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Control pins
   input  wire logic       power_down_n_i,
   input  wire logic       law_select_i,
   // Word to transmit
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   // Word received
   output logic [7:0]      rx_data_o,
   output logic            rx_valid_o,
   // Status
   output logic            halted_o,
   // Link
   vpcm_if.dev             link
);
   // System clock domain
   logic                           pd_s1_r;
   logic                           pd_s2_r;
   logic                           law_s1_r;
   logic                           law_s2_r;
   logic                           bck_s1_r;
   logic                           bck_s2_r;
   logic                           bck_s3_r;
   logic                           xs_s1_r;
   logic                           xs_s2_r;
   logic                           xs_s3_r;
   logic [vpcm_pkg::STUCK_W-1:0]   bck_idle_r;
   logic [vpcm_pkg::STUCK_W-1:0]   xs_idle_r;
   logic                           save_r;
   logic                           halt_r;
   logic [7:0]                     law_mask;
   logic [7:0]                     tx_word_r;
   logic                           tx_req_r;
   logic                           tx_busy_r;
   logic                           ack_s1_r;
   logic                           ack_s2_r;
   logic                           rtg_s1_r;
   logic                           rtg_s2_r;
   logic                           rtg_s3_r;
   // Link clock domain
   logic                           halt_b1_r;
   logic                           halt_b2_r;
   logic                           req_b1_r;
   logic                           req_b2_r;
   logic                           rs_prev_r;
   logic                           rx_act_r;
   logic [vpcm_pkg::BIT_CNT_W-1:0] rx_cnt_r;
   logic [7:0]                     rx_sh_r;
   logic [7:0]                     rx_hold_r;
   logic                           rx_tgl_r;
   logic                           xs_prev_r;
   logic                           tx_act_r;
   logic [vpcm_pkg::BIT_CNT_W-1:0] tx_cnt_r;
   logic [7:0]                     tx_sh_r;
   logic [7:0]                     tx_next_r;
   logic                           tx_fresh_r;
   logic                           tx_ack_r;
   logic                           rs_rise;
   logic                           xs_rise;
   logic                           early_low;

   // System clock side

   // Pin synchronisers; law select resets to mu-law like its pull-down
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pd_s1_r  <= 1'b0;
         pd_s2_r  <= 1'b0;
         law_s1_r <= 1'b0;
         law_s2_r <= 1'b0;
      end
      else
      begin
         pd_s1_r  <= power_down_n_i;
         pd_s2_r  <= pd_s1_r;
         law_s1_r <= law_select_i;
         law_s2_r <= law_s1_r;
      end
   end

   assign law_mask = law_s2_r ? vpcm_pkg::LAW_SELECT_MASK :
                     vpcm_pkg::MULAW_MASK;

   // Watch the link clock and transmit sync for activity
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         bck_s1_r <= 1'b0;
         bck_s2_r <= 1'b0;
         bck_s3_r <= 1'b0;
         xs_s1_r  <= 1'b0;
         xs_s2_r  <= 1'b0;
         xs_s3_r  <= 1'b0;
      end
      else
      begin
         bck_s1_r <= link.bit_clock;
         bck_s2_r <= bck_s1_r;
         bck_s3_r <= bck_s2_r;
         xs_s1_r  <= link.transmit_frame_sync;
         xs_s2_r  <= xs_s1_r;
         xs_s3_r  <= xs_s2_r;
      end
   end

   // Quiet timers start expired, so the port idles until the link runs
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         bck_idle_r <= vpcm_pkg::STUCK_CYC;
         xs_idle_r  <= vpcm_pkg::STUCK_CYC;
         save_r     <= 1'b1;
         halt_r     <= 1'b1;
      end
      else
      begin
         if (bck_s2_r != bck_s3_r)
            bck_idle_r <= '0;
         else if (bck_idle_r != vpcm_pkg::STUCK_CYC)
            bck_idle_r <= bck_idle_r + 12'h001;
         if (xs_s2_r && !xs_s3_r)
            xs_idle_r <= '0;
         else if (xs_idle_r != vpcm_pkg::STUCK_CYC)
            xs_idle_r <= xs_idle_r + 12'h001;
         save_r <= (bck_idle_r == vpcm_pkg::STUCK_CYC) ||
                   (xs_idle_r == vpcm_pkg::STUCK_CYC);
         halt_r <= save_r || !pd_s2_r;
      end
   end

   assign halted_o = halt_r;

   // Transmit word handed over by toggle; held stable until acknowledged
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_word_r <= vpcm_pkg::MU_PLUS_ZERO;
         tx_req_r  <= 1'b0;
         tx_busy_r <= 1'b0;
         ack_s1_r  <= 1'b0;
         ack_s2_r  <= 1'b0;
      end
      else
      begin
         ack_s1_r <= tx_ack_r;
         ack_s2_r <= ack_s1_r;
         if (tx_valid_i && !tx_busy_r)
         begin
            tx_word_r <= tx_data_i ^ law_mask;
            tx_req_r  <= !tx_req_r;
            tx_busy_r <= 1'b1;
         end
         else if (ack_s2_r == tx_req_r)
            tx_busy_r <= 1'b0;
      end
   end

   assign tx_ready_o = !tx_busy_r;

   // Receive word crosses by toggle; the holding register stays a frame
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rtg_s1_r   <= 1'b0;
         rtg_s2_r   <= 1'b0;
         rtg_s3_r   <= 1'b0;
         rx_data_o  <= 8'h00;
         rx_valid_o <= 1'b0;
      end
      else
      begin
         rtg_s1_r   <= rx_tgl_r;
         rtg_s2_r   <= rtg_s1_r;
         rtg_s3_r   <= rtg_s2_r;
         rx_valid_o <= rtg_s2_r != rtg_s3_r;
         if (rtg_s2_r != rtg_s3_r)
            rx_data_o <= rx_hold_r ^ law_mask;
      end
   end

   // Link clock side

   always_ff @(posedge link.bit_clock or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         halt_b1_r <= 1'b1;
         halt_b2_r <= 1'b1;
         req_b1_r  <= 1'b0;
         req_b2_r  <= 1'b0;
      end
      else
      begin
         halt_b1_r <= halt_r;
         halt_b2_r <= halt_b1_r;
         req_b1_r  <= tx_req_r;
         req_b2_r  <= req_b1_r;
      end
   end

   assign rs_rise = link.receive_frame_sync && !rs_prev_r;

   // Receive shifts on falling edges, one word per sync, then ignores
   always_ff @(negedge link.bit_clock or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rs_prev_r <= 1'b0;
         rx_act_r  <= 1'b0;
         rx_cnt_r  <= '0;
         rx_sh_r   <= 8'h00;
         rx_hold_r <= vpcm_pkg::MU_PLUS_ZERO;
         rx_tgl_r  <= 1'b0;
      end
      else
      begin
         rs_prev_r <= link.receive_frame_sync;
         if (halt_b2_r)
            rx_act_r <= 1'b0;
         else if (rs_rise)
         begin
            rx_sh_r  <= {7'h00, link.serial_voice_in};
            rx_cnt_r <= vpcm_pkg::FIRST_CNT;
            rx_act_r <= 1'b1;
         end
         else if (rx_act_r)
         begin
            rx_sh_r  <= {rx_sh_r[6:0], link.serial_voice_in};
            rx_cnt_r <= rx_cnt_r + 3'h1;
            if (rx_cnt_r == vpcm_pkg::LAST_CNT)
            begin
               rx_act_r  <= 1'b0;
               rx_hold_r <= {rx_sh_r[6:0], link.serial_voice_in};
               rx_tgl_r  <= !rx_tgl_r;
            end
         end
      end
   end

   assign xs_rise = link.transmit_frame_sync && !xs_prev_r;

   // Transmit frame starts on the clock edge that sees the sync high
   always_ff @(posedge link.bit_clock or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         xs_prev_r  <= 1'b0;
         tx_act_r   <= 1'b0;
         tx_cnt_r   <= '0;
         tx_sh_r    <= vpcm_pkg::MU_PLUS_ZERO;
         tx_next_r  <= vpcm_pkg::MU_PLUS_ZERO;
         tx_fresh_r <= 1'b0;
         tx_ack_r   <= 1'b0;
      end
      else
      begin
         xs_prev_r <= link.transmit_frame_sync;
         if (halt_b2_r)
            tx_act_r <= 1'b0;
         else if (xs_rise && tx_fresh_r)
         begin
            tx_sh_r  <= tx_next_r;
            tx_cnt_r <= '0;
            tx_act_r <= 1'b1;
         end
         else if (tx_act_r)
         begin
            tx_sh_r  <= tx_sh_r << 1;
            tx_cnt_r <= tx_cnt_r + 3'h1;
            if (tx_cnt_r == vpcm_pkg::LAST_CNT)
               tx_act_r <= 1'b0;
         end
         // A new word arriving as the old one is consumed wins
         if (req_b2_r != tx_ack_r)
         begin
            tx_next_r  <= tx_word_r;
            tx_ack_r   <= req_b2_r;
            tx_fresh_r <= 1'b1;
         end
         else if (!halt_b2_r && xs_rise && tx_fresh_r)
            tx_fresh_r <= 1'b0;
      end
   end

   // Leading bit may appear as soon as the sync rises, before the edge
   assign early_low = xs_rise && tx_fresh_r && !halt_b2_r &&
                      !tx_next_r[7];

   // Pull low only; halt_r also releases a word cut off by a stuck clock
   // Power down reaches the pin only through its synchroniser
   assign link.serial_voice_out_drv = 1'b0;
   assign link.serial_voice_out_oe  =
      (tx_act_r ? !tx_sh_r[7] : early_low) &&
      !halt_r;
endmodule

// *** hw/vpcm_pkg.sv ***
// Constants shared by both ends of the voice PCM serial port
// Behaviour
// - Receive bits sampled on falling bit clock edge
// - Bit at receive sync rise is leading bit
// - One serial bit per bit clock period
// - Far party supplies bit clock at listed rates
// - Stuck bit clock or transmit sync: power saving
// - Receive sync selects word and times receive
// - Far party keeps both syncs locked to clock
// - Far party runs syncs near eight kilohertz
// - Transmit sync aligns all transmit timing
// - Transmit leading bit first, rising edges
// - First transmit bit may follow sync rise
// - Output released outside word and when halted
// - Output open drain; far side pulls up
// - Power down input low halts both paths
// - Law select zero mu-law, one A-law
// - Law select defaults to mu-law
// - A-law inverts even bits both directions
// - Codes follow standard companding formats
package vpcm_pkg;
   // Word framing
   localparam int         WORD_BITS     = 8;
   localparam int         BIT_CNT_W     = 3;
   localparam logic [2:0] FIRST_CNT     = 3'h1;
   localparam logic [2:0] LAST_CNT      = 3'h7;
   // Even bits counted from the leading bit
   localparam logic [7:0] LAW_SELECT_MASK     = 8'h55;
   localparam logic [7:0] MULAW_MASK    = 8'h00;
   // Mu-law reference codes as they appear on the line
   localparam logic [7:0] MU_POS_FULL   = 8'h80;
   localparam logic [7:0] MU_PLUS_ZERO  = 8'hFF;
   localparam logic [7:0] MU_MINUS_ZERO = 8'h7F;
   localparam logic [7:0] MU_NEG_FULL   = 8'h00;
   // Stuck detection, longest quiet time before power saving
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          STUCK_TIME_NS = 200000;
   localparam int          STUCK_W       = 12;
   localparam logic [11:0] STUCK_CYC     =
      12'(STUCK_TIME_NS / CLK_PERIOD_NS);
   // Host link clock divider and frame length
   localparam int          BCLK_HALF_CYC = 5;
   localparam logic [2:0]  DIV_LAST      = 3'(BCLK_HALF_CYC - 1);
   localparam logic [2:0]  SAMPLE_LAG    = 3'h2;
   localparam int          FRAME_BITS    = 250;
   localparam logic [7:0]  FRAME_LAST    = 8'(FRAME_BITS - 1);
   localparam logic [7:0]  WORD_END      = 8'(WORD_BITS);
   localparam logic [7:0]  WORD_LAST     = 8'(WORD_BITS - 1);
endpackage

// *** hw/vpcm_if.sv ***
// Link wires between the highway master and the codec port
`timescale 1ns/1ns
interface vpcm_if;
   logic bit_clock;
   logic receive_frame_sync;
   logic transmit_frame_sync;
   logic serial_voice_in;
   logic serial_voice_out_drv;
   logic serial_voice_out_oe;
   logic serial_voice_out;

   // External pull-up on the open drain line
   assign serial_voice_out = serial_voice_out_oe ?
                             serial_voice_out_drv : 1'b1;

   modport dev
   (
      input  bit_clock,
      input  receive_frame_sync,
      input  transmit_frame_sync,
      input  serial_voice_in,
      output serial_voice_out_drv,
      output serial_voice_out_oe
   );

   modport host
   (
      output bit_clock,
      output receive_frame_sync,
      output transmit_frame_sync,
      output serial_voice_in,
      input  serial_voice_out
   );
endinterface

// *** hw/vpcm_host.sv ***
// Highway master end: makes bit clock, frame syncs and receive data
`timescale 1ns/1ns
module vpcm_host
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Control
   input  wire logic       run_i,
   // Word to send to the codec
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   // Word read from the codec
   output logic [7:0]      rx_data_o,
   output logic            rx_valid_o,
   // Link
   vpcm_if.host            link
);
   logic [2:0] div_r;
   logic       bclk_r;
   logic [7:0] bit_r;
   logic [7:0] bit_nxt;
   logic       rise_evt;
   logic       fall_evt;
   logic       receive_frame_sync_r;
   logic       transmit_frame_sync_r;
   logic       din_r;
   logic [7:0] fw_r;
   logic [7:0] tx_word_r;
   logic       tx_pend_r;
   logic       ln_s1_r;
   logic       ln_s2_r;
   logic [7:0] rx_sh_r;

   assign rise_evt = run_i && div_r == vpcm_pkg::DIV_LAST && !bclk_r;
   assign fall_evt = run_i && div_r == vpcm_pkg::DIV_LAST && bclk_r;
   assign bit_nxt  = (bit_r == vpcm_pkg::FRAME_LAST) ? 8'h00 :
                     bit_r + 8'h01;

   // Divider; stopping it leaves the clock stuck for power saving tests
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         div_r  <= 3'h0;
         bclk_r <= 1'b0;
      end
      else if (run_i)
      begin
         div_r <= (div_r == vpcm_pkg::DIV_LAST) ? 3'h0 : div_r + 3'h1;
         if (div_r == vpcm_pkg::DIV_LAST)
            bclk_r <= !bclk_r;
      end
   end

   // Frame position, receive sync and serial data change on rising edges
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         bit_r   <= vpcm_pkg::FRAME_LAST;
         receive_frame_sync_r <= 1'b0;
         din_r   <= 1'b1;
         fw_r    <= vpcm_pkg::MU_PLUS_ZERO;
      end
      else if (rise_evt)
      begin
         bit_r   <= bit_nxt;
         receive_frame_sync_r <= (bit_nxt == 8'h00);
         if (bit_nxt == 8'h00)
         begin
            fw_r  <= (tx_pend_r ? tx_word_r : vpcm_pkg::MU_PLUS_ZERO) << 1;
            din_r <= tx_pend_r ? tx_word_r[7] : 1'b1;
         end
         else if (bit_nxt < vpcm_pkg::WORD_END)
         begin
            din_r <= fw_r[7];
            fw_r  <= fw_r << 1;
         end
         else
            din_r <= 1'b1;
      end
   end

   // Transmit sync straddles the rising edge that opens bit zero
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         transmit_frame_sync_r <= 1'b0;
      else if (fall_evt)
         transmit_frame_sync_r <= (bit_r == vpcm_pkg::FRAME_LAST);
   end

   // One pending word; taken at the next frame start
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_pend_r <= 1'b0;
         tx_word_r <= vpcm_pkg::MU_PLUS_ZERO;
      end
      else if (tx_valid_i && !tx_pend_r)
      begin
         tx_pend_r <= 1'b1;
         tx_word_r <= tx_data_i;
      end
      else if (rise_evt && bit_nxt == 8'h00)
         tx_pend_r <= 1'b0;
   end

   assign tx_ready_o = !tx_pend_r;

   // Line comes from the codec's clock side
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ln_s1_r <= 1'b1;
         ln_s2_r <= 1'b1;
      end
      else
      begin
         ln_s1_r <= link.serial_voice_out;
         ln_s2_r <= ln_s1_r;
      end
   end

   // Sample just after each falling edge in the word slot, allowing for synchroniser lag
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rx_sh_r    <= 8'h00;
         rx_data_o  <= 8'h00;
         rx_valid_o <= 1'b0;
      end
      else
      begin
         rx_valid_o <= 1'b0;
         if (run_i && !bclk_r && div_r == vpcm_pkg::SAMPLE_LAG &&
             bit_r < vpcm_pkg::WORD_END)
         begin
            rx_sh_r <= {rx_sh_r[6:0], ln_s2_r};
            if (bit_r == vpcm_pkg::WORD_LAST)
            begin
               rx_data_o  <= {rx_sh_r[6:0], ln_s2_r};
               rx_valid_o <= 1'b1;
            end
         end
      end
   end

   assign link.bit_clock           = bclk_r;
   assign link.receive_frame_sync  = receive_frame_sync_r;
   assign link.transmit_frame_sync = transmit_frame_sync_r;
   assign link.serial_voice_in     = din_r;
endmodule

// *** tb/vpcm_assertions.sv ***
// Link protocol checker for the voice PCM serial port
`timescale 1ns/1ns
module vpcm_assertions
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Link signals
   input  wire logic bit_clock,
   input  wire logic receive_frame_sync,
   input  wire logic transmit_frame_sync,
   input  wire logic serial_voice_in,
   input  wire logic serial_voice_out_drv,
   input  wire logic serial_voice_out_oe,
   input  wire logic serial_voice_out
);
   logic [3:0] tx_bit_r;
   logic [8:0] frame_bit_r;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Saturates, so a missing transmit sync keeps the line released
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tx_bit_r <= 4'hF;
      else if ($rose(transmit_frame_sync))
         tx_bit_r <= 4'h0;
      else if ($rose(bit_clock) && tx_bit_r != 4'hF)
         tx_bit_r <= tx_bit_r + 4'h1;
   end

   // All ones until the first receive sync, so the first frame passes
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         frame_bit_r <= 9'h1FF;
      else if ($rose(receive_frame_sync))
         frame_bit_r <= 9'h000;
      else if ($rose(bit_clock) && frame_bit_r != 9'h1FF)
         frame_bit_r <= frame_bit_r + 9'h001;
   end

   property p_drive_low;
      serial_voice_out_oe |-> !serial_voice_out_drv && !serial_voice_out;
   endproperty
   a_drive_low : assert property (p_drive_low)
      else $error("open drain output drove a high level");

   // Early leading bit rises with the sync, before the count restarts
   property p_release;
      tx_bit_r > 4'h8 && !$rose(transmit_frame_sync) |->
         !serial_voice_out_oe;
   endproperty
   a_release : assert property (p_release)
      else $error("output driven outside the eight bit word");

   property p_oe_start;
      $rose(serial_voice_out_oe) |->
         tx_bit_r < 4'h8 || $rose(transmit_frame_sync);
   endproperty
   a_oe_start : assert property (p_oe_start)
      else $error("output began driving after the word slot");

   property p_out_edge;
      $changed(serial_voice_out) |->
         $rose(bit_clock) || $rose(transmit_frame_sync);
   endproperty
   a_out_edge : assert property (p_out_edge)
      else $error("output changed away from a clock or sync rise");

   property p_receive_frame_sync_edge;
      $changed(receive_frame_sync) |-> $rose(bit_clock);
   endproperty
   a_receive_frame_sync_edge : assert property (p_receive_frame_sync_edge)
      else $error("receive sync not locked to bit clock");

   property p_transmit_frame_sync_edge;
      $changed(transmit_frame_sync) |-> $fell(bit_clock);
   endproperty
   a_transmit_frame_sync_edge : assert property (p_transmit_frame_sync_edge)
      else $error("transmit sync not locked to bit clock");

   property p_din_edge;
      $changed(serial_voice_in) |-> $rose(bit_clock);
   endproperty
   a_din_edge : assert property (p_din_edge)
      else $error("input data changed off a bit clock rise");

   property p_frame_len;
      $rose(receive_frame_sync) |->
         frame_bit_r == 9'h0F9 || frame_bit_r == 9'h1FF;
   endproperty
   a_frame_len : assert property (p_frame_len)
      else $error("frame length is not 250 bits");

   property p_sync_width;
      $rose(receive_frame_sync) |->
         receive_frame_sync[*8] ##[1:3] !receive_frame_sync;
   endproperty
   a_sync_width : assert property (p_sync_width)
      else $error("receive sync not one bit period wide");

   c_drive : cover property ($rose(serial_voice_out_oe));
   c_frame : cover property ($rose(receive_frame_sync));
   c_last_bit : cover property (tx_bit_r == 4'h8 && serial_voice_out_oe);
endmodule

// *** tb/tb_voice_pcm_serial_port.sv ***
// Self-checking bench joining both ends of the voice PCM serial port
`timescale 1ns/1ns
module tb_voice_pcm_serial_port;
   logic       clk_i        = 1'b0;
   logic       rst_n_i      = 1'b0;
   logic       run          = 1'b0;
   logic       power_down_n = 1'b1;
   logic       law_select   = 1'b0;
   logic [7:0] h_tx_data    = 8'h00;
   logic       h_tx_valid   = 1'b0;
   logic [7:0] d_tx_data    = 8'h00;
   logic       d_tx_valid   = 1'b0;
   logic       h_tx_ready;
   logic       d_tx_ready;
   logic [7:0] h_rx_data;
   logic [7:0] d_rx_data;
   logic       h_rx_valid;
   logic       d_rx_valid;
   logic       d_halted;
   int         n_errors     = 0;
   int         num_checks   = 0;
   int         cyc          = 0;
   int         dev_rx_cnt   = 0;
   // Line codes: mu-law rows, then A-law rows
   logic [7:0] codes [8] = '{vpcm_pkg::MU_POS_FULL, vpcm_pkg::MU_PLUS_ZERO,
      vpcm_pkg::MU_MINUS_ZERO, vpcm_pkg::MU_NEG_FULL,
      8'hAA, 8'hD5, 8'h55, 8'h2A};

   vpcm_if link ();

   vpcm_host i_vpcm_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run),
      .tx_data_i(h_tx_data), .tx_valid_i(h_tx_valid),
      .tx_ready_o(h_tx_ready), .rx_data_o(h_rx_data),
      .rx_valid_o(h_rx_valid), .link(link.host));

   vpcm_device i_vpcm_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .power_down_n_i(power_down_n), .law_select_i(law_select),
      .tx_data_i(d_tx_data), .tx_valid_i(d_tx_valid),
      .tx_ready_o(d_tx_ready), .rx_data_o(d_rx_data),
      .rx_valid_o(d_rx_valid), .halted_o(d_halted), .link(link.dev));

   vpcm_assertions i_vpcm_assertions (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .bit_clock(link.bit_clock),
      .receive_frame_sync(link.receive_frame_sync),
      .transmit_frame_sync(link.transmit_frame_sync),
      .serial_voice_in(link.serial_voice_in),
      .serial_voice_out_drv(link.serial_voice_out_drv),
      .serial_voice_out_oe(link.serial_voice_out_oe),
      .serial_voice_out(link.serial_voice_out));

   always #25 clk_i = ~clk_i;

   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Whole run needs roughly 62000 cycles
   always @(negedge clk_i)
   begin
      cyc++;
      if (d_rx_valid === 1'b1)
         dev_rx_cnt++;
      if (cyc == 90000)
      begin
         n_errors++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [7:0] seen,
                      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic push(input bit to_dev, input logic [7:0] w);
      int k;
      k = 0;
      @(negedge clk_i);
      while ((to_dev ? d_tx_ready : h_tx_ready) !== 1'b1 && k < 6000)
      begin
         @(negedge clk_i);
         k++;
      end
      if (to_dev)
      begin
         d_tx_data  = w;
         d_tx_valid = 1'b1;
      end
      else
      begin
         h_tx_data  = w;
         h_tx_valid = 1'b1;
      end
      @(negedge clk_i);
      d_tx_valid = 1'b0;
      h_tx_valid = 1'b0;
   endtask

   // Timeout hands back unknown data so the compare fails
   task automatic get_rx(input bit from_dev, output logic [7:0] d);
      int k;
      k = 0;
      do
      begin
         @(negedge clk_i);
         k++;
      end
      while ((from_dev ? d_rx_valid : h_rx_valid) !== 1'b1 && k < 6000);
      d = (k < 6000) ? (from_dev ? d_rx_data : h_rx_data) : 8'hXX;
   endtask

   task automatic wait_halt(input logic lvl, output int n);
      n = 0;
      while (d_halted !== lvl && n < 12000)
      begin
         @(negedge clk_i);
         n++;
      end
   endtask

   task automatic t_xfer(input int i);
      logic [7:0] m;
      logic [7:0] hs;
      logic [7:0] ds;
      m = i[2] ? vpcm_pkg::LAW_SELECT_MASK : vpcm_pkg::MULAW_MASK;
      @(negedge clk_i);
      law_select = i[2];
      get_rx(1'b0, hs);
      chk("idle frame", hs, 8'hFF);
      push(1'b1, codes[i] ^ m);
      push(1'b0, codes[i]);
      fork
         get_rx(1'b0, hs);
         get_rx(1'b1, ds);
      join
      chk("line word", hs, codes[i]);
      chk("received word", ds, codes[i] ^ m);
   endtask

   task automatic t_power_down;
      logic [7:0] hs;
      int         n;
      int         c0;
      get_rx(1'b0, hs);
      @(negedge clk_i);
      power_down_n = 1'b0;
      wait_halt(1'b1, n);
      chk("power down halt", {7'h00, n <= 10}, 8'h01);
      c0 = dev_rx_cnt;
      push(1'b0, 8'h3C);
      get_rx(1'b0, hs);
      repeat (20) @(negedge clk_i);
      chk("line in power down", hs, 8'hFF);
      chk("capture in power down", 8'(dev_rx_cnt - c0), 8'h00);
      power_down_n = 1'b1;
      wait_halt(1'b0, n);
      chk("power up", {7'h00, d_halted}, 8'h00);
   endtask

   task automatic t_stuck;
      logic [7:0] hs;
      int         n;
      get_rx(1'b0, hs);
      chk("idle frame", hs, 8'hFF);
      @(negedge clk_i);
      run = 1'b0;
      wait_halt(1'b1, n);
      // Bounded only from above: quiet time starts at the last sync edge
      chk("stuck halt", {7'h00, n <= int'(vpcm_pkg::STUCK_CYC) + 20},
          8'h01);
      chk("line when stuck", {7'h00, link.serial_voice_out}, 8'h01);
      run = 1'b1;
      wait_halt(1'b0, n);
      chk("stuck resume", {7'h00, d_halted}, 8'h00);
   endtask

   initial
   begin
      int n;
      repeat (16) @(negedge clk_i);
      chk("halt in reset", {7'h00, d_halted}, 8'h01);
      chk("line in reset", {7'h00, link.serial_voice_out}, 8'h01);
      rst_n_i = 1'b1;
      run     = 1'b1;
      wait_halt(1'b0, n);
      chk("wake", {7'h00, d_halted}, 8'h00);
      for (int i = 0; i < 8; i++)
         t_xfer(i);
      t_power_down();
      t_xfer(1);
      t_stuck();
      t_xfer(6);
      finish_test();
   end
endmodule
